// >>> rtl/rtc_pkg.sv
// Constants and types shared by the time-of-day clock digit access logic.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package rtc_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // Command port field positions
  localparam int unsigned CMD_HOLD_BIT  = 6;
  localparam int unsigned CMD_WRITE_BIT = 5;
  localparam int unsigned CMD_READ_BIT  = 4;

  // Digit selector codes
  localparam logic [3:0] SEL_SEC_U  = 4'h0;
  localparam logic [3:0] SEL_SEC_T  = 4'h1;
  localparam logic [3:0] SEL_MIN_U  = 4'h2;
  localparam logic [3:0] SEL_MIN_T  = 4'h3;
  localparam logic [3:0] SEL_HR_U   = 4'h4;
  localparam logic [3:0] SEL_HR_T   = 4'h5;
  localparam logic [3:0] SEL_WDAY   = 4'h6;
  localparam logic [3:0] SEL_DAY_U  = 4'h7;
  localparam logic [3:0] SEL_DAY_T  = 4'h8;
  localparam logic [3:0] SEL_MON_U  = 4'h9;
  localparam logic [3:0] SEL_MON_T  = 4'hA;
  localparam logic [3:0] SEL_YR_U   = 4'hB;
  localparam logic [3:0] SEL_YR_T   = 4'hC;
  localparam int unsigned NUM_DIGITS = 13;

  // Special bits inside hours-tens and day-tens digits
  localparam int unsigned HR_T_24H_BIT  = 3;
  localparam int unsigned HR_T_PM_BIT   = 2;
  localparam int unsigned DAY_T_LEAP_BIT = 2;

  // Reset values: 24 hour mode, 00:00:00, day 01, month 01, year 00
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [3:0] HR_T_RESET  = 4'h8;
  localparam logic [3:0] DAY_U_RESET = 4'h1;
  localparam logic [3:0] MON_U_RESET = 4'h1;

  // Calendar limits in BCD
  localparam logic [7:0] BCD_FEB     = 8'h02;
  localparam logic [7:0] BCD_APR     = 8'h04;
  localparam logic [7:0] BCD_JUN     = 8'h06;
  localparam logic [7:0] BCD_SEP     = 8'h09;
  localparam logic [7:0] BCD_NOV     = 8'h11;
  localparam logic [7:0] BCD_DEC     = 8'h12;
  localparam logic [7:0] BCD_DAYS_28 = 8'h28;
  localparam logic [7:0] BCD_DAYS_29 = 8'h29;
  localparam logic [7:0] BCD_DAYS_30 = 8'h30;
  localparam logic [7:0] BCD_DAYS_31 = 8'h31;
  localparam logic [3:0] WDAY_LAST   = 4'h6;

  // Command byte as the host writes it
  typedef struct packed {
    logic       unused;
    logic       hold;
    logic       wr;
    logic       rd;
    logic [3:0] sel;
  } cmd_t;

endpackage

// >>> rtl/rtc_second_tick.sv
// One-second timebase: a free-running divider giving a one-cycle enable pulse.
// Assumes the system clock and synchronous reset of the clock block.
`timescale 1ns/1ps
module rtc_second_tick #(
  parameter int unsigned CYCLES = rtc_pkg::SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Tick
  output logic      tick_o
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == CYCLES - 1);
    nxt_cnt  = nxt_tick ? 32'h0 : cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule

// >>> rtl/rtc_digit_access_port.sv
// Time-of-day clock and calendar reached through a command port and a digit data port.
// Assumes host strobes are synchronous to clk_i and last one cycle per port access.
`timescale 1ns/1ps
// Summary of operation
// - A data port read returns the selected digit as BCD in bits 3..0.
// - Bits 7..4 of every data port read are zero.
// - Any digit may be selected and read in any order.
// - Command bit 6 set stops all time and date counting.
// - Seconds lost while frozen are not made up afterwards.
// - Command bit 5 set copies the data port value into the selected digit, minutes units through year tens.
// - Command bit 4 set puts the selected digit on the data port.
// - Selector codes 0 to 12 pick seconds units through year tens.
// - Hours tens digit also holds 12/24 hour mode and AM/PM.
// - Hours tens bit 3 is 24 hour mode, bit 2 PM, bits 1..0 tens.
// - Day tens bit 2 grants February 29 days, cleared after the 29th.
// - Writing either seconds digit loads zero whatever data is given.
module rtc_digit_access_port #(
  parameter int unsigned SECOND_CYCLES = rtc_pkg::SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Host port accesses
  input  wire logic       cmd_wr_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] wdata_i,
  // Data port read value
  output logic [7:0]      rdata_o
);

  rtc_pkg::cmd_t cmd_ff;
  rtc_pkg::cmd_t nxt_cmd;
  logic [3:0]    data_ff;
  logic [3:0]    nxt_data;
  logic [7:0]    rdata_ff;
  logic [7:0]    nxt_rdata;
  logic [3:0]    dig_ff  [rtc_pkg::NUM_DIGITS];
  logic [3:0]    nxt_dig [rtc_pkg::NUM_DIGITS];
  logic          tick;
  logic          c_min;
  logic          c_hr;
  logic          c_day;
  logic          c_mon;
  logic          c_yr;
  logic [7:0]    day_bcd;
  logic [7:0]    mon_bcd;
  logic [7:0]    day_max;
  logic [3:0]    hr_t;

  rtc_second_tick #(
    .CYCLES (SECOND_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Host-facing registers
  always_comb begin
    nxt_cmd   = cmd_wr_i ? rtc_pkg::cmd_t'(wdata_i) : cmd_ff;
    nxt_data  = data_wr_i ? wdata_i[3:0] : data_ff;
    nxt_rdata = 8'h00;
    if (cmd_ff.rd && cmd_ff.sel <= rtc_pkg::SEL_YR_T) begin
      nxt_rdata[3:0] = dig_ff[cmd_ff.sel];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff   <= rtc_pkg::cmd_t'(rtc_pkg::CMD_RESET);
      data_ff  <= 4'h0;
      rdata_ff <= 8'h00;
    end else begin
      cmd_ff   <= nxt_cmd;
      data_ff  <= nxt_data;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  // Calendar counting and digit writes
  always_comb begin
    nxt_dig = dig_ff;
    c_min   = 1'b0;
    c_hr    = 1'b0;
    c_day   = 1'b0;
    c_mon   = 1'b0;
    c_yr    = 1'b0;
    hr_t    = dig_ff[rtc_pkg::SEL_HR_T];
    day_bcd = {2'b00, dig_ff[rtc_pkg::SEL_DAY_T][1:0], dig_ff[rtc_pkg::SEL_DAY_U]};
    mon_bcd = {dig_ff[rtc_pkg::SEL_MON_T], dig_ff[rtc_pkg::SEL_MON_U]};
    if (mon_bcd == rtc_pkg::BCD_FEB) begin
      day_max = dig_ff[rtc_pkg::SEL_DAY_T][rtc_pkg::DAY_T_LEAP_BIT] ?
                rtc_pkg::BCD_DAYS_29 : rtc_pkg::BCD_DAYS_28;
    end else if (mon_bcd == rtc_pkg::BCD_APR || mon_bcd == rtc_pkg::BCD_JUN ||
                 mon_bcd == rtc_pkg::BCD_SEP || mon_bcd == rtc_pkg::BCD_NOV) begin
      day_max = rtc_pkg::BCD_DAYS_30;
    end else begin
      day_max = rtc_pkg::BCD_DAYS_31;
    end
    // Ticks arriving while frozen are dropped, not queued
    if (tick && !cmd_ff.hold) begin
      if (dig_ff[0] == 4'h9) begin
        nxt_dig[0] = 4'h0;
        if (dig_ff[1] == 4'h5) begin
          nxt_dig[1] = 4'h0;
          c_min      = 1'b1;
        end else begin
          nxt_dig[1] = dig_ff[1] + 4'h1;
        end
      end else begin
        nxt_dig[0] = dig_ff[0] + 4'h1;
      end
      if (c_min) begin
        if (dig_ff[2] == 4'h9) begin
          nxt_dig[2] = 4'h0;
          if (dig_ff[3] == 4'h5) begin
            nxt_dig[3] = 4'h0;
            c_hr       = 1'b1;
          end else begin
            nxt_dig[3] = dig_ff[3] + 4'h1;
          end
        end else begin
          nxt_dig[2] = dig_ff[2] + 4'h1;
        end
      end
      if (c_hr) begin
        if (hr_t[rtc_pkg::HR_T_24H_BIT]) begin
          if (hr_t[1:0] == 2'd2 && dig_ff[4] == 4'h3) begin
            nxt_dig[4] = 4'h0;
            nxt_dig[5] = {hr_t[3:2], 2'd0};
            c_day      = 1'b1;
          end else if (dig_ff[4] == 4'h9) begin
            nxt_dig[4] = 4'h0;
            nxt_dig[5] = {hr_t[3:2], hr_t[1:0] + 2'd1};
          end else begin
            nxt_dig[4] = dig_ff[4] + 4'h1;
          end
        end else if (hr_t[0] && dig_ff[4] == 4'h2) begin
          nxt_dig[4] = 4'h1;
          nxt_dig[5] = {hr_t[3:2], 2'd0};
        end else if (hr_t[0] && dig_ff[4] == 4'h1) begin
          nxt_dig[4] = 4'h2;
          nxt_dig[5] = {hr_t[3], ~hr_t[2], 2'd1};
          c_day      = hr_t[rtc_pkg::HR_T_PM_BIT];
        end else if (dig_ff[4] == 4'h9) begin
          nxt_dig[4] = 4'h0;
          nxt_dig[5] = {hr_t[3:2], 2'd1};
        end else begin
          nxt_dig[4] = dig_ff[4] + 4'h1;
        end
      end
      if (c_day) begin
        nxt_dig[6] = (dig_ff[6] == rtc_pkg::WDAY_LAST) ? 4'h0 : dig_ff[6] + 4'h1;
        if (day_bcd == day_max) begin
          nxt_dig[7] = rtc_pkg::DAY_U_RESET;
          nxt_dig[8] = {dig_ff[8][3], dig_ff[8][2], 2'd0};
          if (day_bcd == rtc_pkg::BCD_DAYS_29 && mon_bcd == rtc_pkg::BCD_FEB) begin
            nxt_dig[8][rtc_pkg::DAY_T_LEAP_BIT] = 1'b0;
          end
          c_mon = 1'b1;
        end else if (dig_ff[7] == 4'h9) begin
          nxt_dig[7] = 4'h0;
          nxt_dig[8] = {dig_ff[8][3:2], dig_ff[8][1:0] + 2'd1};
        end else begin
          nxt_dig[7] = dig_ff[7] + 4'h1;
        end
      end
      if (c_mon) begin
        if (mon_bcd == rtc_pkg::BCD_DEC) begin
          nxt_dig[9]  = rtc_pkg::MON_U_RESET;
          nxt_dig[10] = 4'h0;
          c_yr        = 1'b1;
        end else if (dig_ff[9] == 4'h9) begin
          nxt_dig[9]  = 4'h0;
          nxt_dig[10] = dig_ff[10] + 4'h1;
        end else begin
          nxt_dig[9] = dig_ff[9] + 4'h1;
        end
      end
      if (c_yr) begin
        nxt_dig[11] = (dig_ff[11] == 4'h9) ? 4'h0 : dig_ff[11] + 4'h1;
        if (dig_ff[11] == 4'h9) begin
          nxt_dig[12] = (dig_ff[12] == 4'h9) ? 4'h0 : dig_ff[12] + 4'h1;
        end
      end
    end
    // Host write wins over counting; counting resumes from what is stored
    if (cmd_ff.wr && cmd_ff.sel <= rtc_pkg::SEL_YR_T) begin
      if (cmd_ff.sel <= rtc_pkg::SEL_SEC_T) begin
        nxt_dig[cmd_ff.sel] = 4'h0;
      end else begin
        nxt_dig[cmd_ff.sel] = data_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < rtc_pkg::NUM_DIGITS; i++) begin
        dig_ff[i] <= 4'h0;
      end
      dig_ff[rtc_pkg::SEL_HR_T]  <= rtc_pkg::HR_T_RESET;
      dig_ff[rtc_pkg::SEL_DAY_U] <= rtc_pkg::DAY_U_RESET;
      dig_ff[rtc_pkg::SEL_MON_U] <= rtc_pkg::MON_U_RESET;
    end else begin
      dig_ff <= nxt_dig;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence read_year_tens;
    cmd_ff.rd && cmd_ff.sel == rtc_pkg::SEL_YR_T;
  endsequence

  chk_read_digit_low: assert property (
    read_year_tens |=> rdata_o[3:0] == $past(dig_ff[12]))
    else $error("data port low nibble does not match selected digit");

  chk_read_high_zero: assert property (
    rdata_o[7:4] == 4'h0)
    else $error("data port high nibble not zero");

  chk_random_select: assert property (
    cmd_wr_i && wdata_i[rtc_pkg::CMD_READ_BIT] && wdata_i[3:0] == rtc_pkg::SEL_DAY_U
    |=> ##1 rdata_o[3:0] == $past(dig_ff[7]))
    else $error("randomly selected digit not presented two cycles later");

  chk_hold_freezes: assert property (
    cmd_ff.hold && !cmd_ff.wr |=> $stable(dig_ff[0]) && $stable(dig_ff[2]))
    else $error("counters advanced while frozen");

  chk_no_catch_up: assert property (
    !tick && !cmd_ff.wr |=> $stable(dig_ff[0]))
    else $error("seconds changed without a timebase tick");

  chk_write_digit: assert property (
    cmd_ff.wr && cmd_ff.sel == rtc_pkg::SEL_MIN_U |=> dig_ff[2] == $past(data_ff))
    else $error("write strobe did not load minutes units");

  chk_seconds_zero: assert property (
    cmd_ff.wr && cmd_ff.sel == rtc_pkg::SEL_SEC_T |=> dig_ff[1] == 4'h0)
    else $error("seconds tens write did not load zero");

  chk_cmd_retained: assert property (
    !cmd_wr_i |=> $stable(cmd_ff))
    else $error("command port changed without a write");

endmodule

// >>> test/rtc_host_model.sv
// Host processor model: command and data port writes, frozen digit reads.
// Assumes the bench calls its tasks; accesses launch on the falling clock edge.
`timescale 1ns/1ps
module rtc_host_model (
  // Clock
  input  wire logic       clk_i,
  // Port accesses
  output logic            cmd_wr_o,
  output logic            data_wr_o,
  output logic [7:0]      wdata_o,
  // Data port
  input  wire logic [7:0] rdata_i
);
  initial begin
    cmd_wr_o  = 1'b0;
    data_wr_o = 1'b0;
    wdata_o   = 8'h00;
  end

  // One port write; the released byte is scrambled so a stale value cannot pass
  task automatic put(input logic is_cmd, input logic [7:0] v);
    @(negedge clk_i);
    cmd_wr_o  = is_cmd;
    data_wr_o = ~is_cmd;
    wdata_o   = v;
    @(negedge clk_i);
    cmd_wr_o  = 1'b0;
    data_wr_o = 1'b0;
    wdata_o   = ~v;
  endtask

  // Digit set sequence; high nibble of the data byte is junk on purpose
  task automatic set_digit(input logic [3:0] sel, input logic [3:0] v);
    put(1'b1, {4'h4, sel});
    put(1'b0, {4'hA, v});
    put(1'b1, {4'h6, sel});
    put(1'b1, {4'h4, sel});
  endtask

  // Read with the freeze bit set, sampled once the registered port caught up
  task automatic get_digit(input logic [3:0] sel, output logic [7:0] v);
    put(1'b1, {4'h5, sel});
    @(negedge clk_i);
    @(negedge clk_i);
    v = rdata_i;
  endtask
endmodule

// >>> test/tb_rtc_digit_access_port.sv
// Self-checking bench for the clock digit access port.
// Assumes a shortened second of 20 cycles; the host model drives all port writes.
`timescale 1ns/1ps
module tb_rtc_digit_access_port;
  localparam int unsigned SC     = 20;
  localparam int unsigned MINUTE = 60 * SC + 25;
  localparam logic [3:0] RESET_DIGIT [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h0,
                                              4'h1, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
  logic       clk_i;
  logic       rst_i;
  logic       cmd_wr_i;
  logic       data_wr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic [7:0] got;
  int         fail_count;
  int         total_checks;

  rtc_digit_access_port #(.SECOND_CYCLES(SC)) dut (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cmd_wr_i  (cmd_wr_i),
    .data_wr_i (data_wr_i),
    .wdata_i   (wdata_i),
    .rdata_o   (rdata_o)
  );

  rtc_host_model host (
    .clk_i     (clk_i),
    .cmd_wr_o  (cmd_wr_i),
    .data_wr_o (data_wr_i),
    .wdata_o   (wdata_i),
    .rdata_i   (rdata_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_digit(input logic [3:0] sel, input logic [3:0] exp);
    host.get_digit(sel, got);
    check(got, {4'h0, exp});
  endtask

  // Loads hours and 59 minutes with the clock frozen
  task automatic set_time(input logic [3:0] ht, input logic [3:0] hu);
    host.set_digit(rtc_pkg::SEL_HR_T, ht);
    host.set_digit(rtc_pkg::SEL_HR_U, hu);
    host.set_digit(rtc_pkg::SEL_MIN_T, 4'h5);
    host.set_digit(rtc_pkg::SEL_MIN_U, 4'h9);
  endtask

  // Counts a little over one minute, then freezes again
  task automatic run_minute;
    host.put(1'b1, 8'h00);
    repeat (MINUTE) @(negedge clk_i);
    host.put(1'b1, 8'h40);
  endtask

  initial begin
    repeat (100000) @(negedge clk_i);
    fail_count++;
    stop_test;
  end

  initial begin
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    // Reset contents, top digit first
    for (int i = 12; i >= 0; i--) begin
      expect_digit(4'(i), RESET_DIGIT[i]);
    end
    // Command stays in force; repeated reads need no rewrite
    expect_digit(rtc_pkg::SEL_HR_T, 4'h8);
    repeat (SC) @(negedge clk_i);
    check(rdata_o, 8'h08);
    // Read bit clear or selector beyond year tens gives zero
    host.put(1'b1, 8'h5D);
    repeat (2) @(negedge clk_i);
    check(rdata_o, 8'h00);
    host.put(1'b1, 8'h45);
    repeat (2) @(negedge clk_i);
    check(rdata_o, 8'h00);
    // Unfrozen reads follow the count: one step in any window of one second
    host.put(1'b1, 8'h10);
    repeat (2) @(negedge clk_i);
    got = rdata_o;
    repeat (SC) @(negedge clk_i);
    check(rdata_o, (got[3:0] == 4'h9) ? 8'h00 : got + 8'h01);
    // Frozen seconds stay put; ticks skipped meanwhile are lost
    host.get_digit(rtc_pkg::SEL_SEC_U, got);
    repeat (3 * SC) @(negedge clk_i);
    check(rdata_o, got);
    // Set 23:59 and try to load seconds
    host.put(1'b1, 8'h40);
    host.set_digit(rtc_pkg::SEL_SEC_U, 4'h7);
    host.set_digit(rtc_pkg::SEL_SEC_T, 4'h5);
    set_time(4'hA, 4'h3);
    repeat (3 * SC) @(negedge clk_i);
    expect_digit(rtc_pkg::SEL_SEC_U, 4'h0);
    expect_digit(rtc_pkg::SEL_SEC_T, 4'h0);
    expect_digit(rtc_pkg::SEL_MIN_U, 4'h9);
    expect_digit(rtc_pkg::SEL_HR_T, 4'hA);
    // Midnight rollover from the written values
    run_minute;
    expect_digit(rtc_pkg::SEL_MIN_U, 4'h0);
    expect_digit(rtc_pkg::SEL_MIN_T, 4'h0);
    expect_digit(rtc_pkg::SEL_HR_U, 4'h0);
    expect_digit(rtc_pkg::SEL_HR_T, 4'h8);
    expect_digit(rtc_pkg::SEL_WDAY, 4'h1);
    expect_digit(rtc_pkg::SEL_DAY_U, 4'h2);
    // 12 hour mode: 11:59 AM becomes 12:00 PM
    set_time(4'h1, 4'h1);
    run_minute;
    expect_digit(rtc_pkg::SEL_HR_T, 4'h5);
    expect_digit(rtc_pkg::SEL_HR_U, 4'h2);
    // Leap year: Feb 28 to Feb 29, then to Mar 1 with the flag cleared
    host.set_digit(rtc_pkg::SEL_MON_U, 4'h2);
    host.set_digit(rtc_pkg::SEL_DAY_T, 4'h6);
    host.set_digit(rtc_pkg::SEL_DAY_U, 4'h8);
    set_time(4'hA, 4'h3);
    run_minute;
    expect_digit(rtc_pkg::SEL_DAY_U, 4'h9);
    expect_digit(rtc_pkg::SEL_DAY_T, 4'h6);
    set_time(4'hA, 4'h3);
    run_minute;
    expect_digit(rtc_pkg::SEL_DAY_U, 4'h1);
    expect_digit(rtc_pkg::SEL_DAY_T, 4'h0);
    expect_digit(rtc_pkg::SEL_MON_U, 4'h3);
    stop_test;
  end
endmodule
